/* File: src/adjust_consts.svh */
`ifndef ADJUST_CONSTS_SVH
`define ADJUST_CONSTS_SVH
// parameter ids and register reset value
`define REG_FB_OFFSET   8'h44
`define REG_ADJ_CMD     8'h85
`define REG_RESET_VAL   16'h0000
// adjustment function codes
`define FN_PHASING      16'h0004
`define FN_FIX_ANGLE    16'h0005
`define FN_ANALOG_OFS   16'h0006
`define FN_TACHO_OFS    16'h0007
// two-digit status codes, one decimal digit per nibble
`define ST_NONE         8'h00
`define ST_PH_ACCEPT    8'h40
`define ST_PH_ENABLED   8'h41
`define ST_PH_CURRENT   8'h42
`define ST_PH_POLES     8'h43
`define ST_PH_ENA_LOST  8'h47
`define ST_PH_TIMEOUT   8'h48
`define ST_PH_DONE      8'h49
`define ST_AN_ACCEPT    8'h60
`define ST_AN_ENA_ON    8'h66
`define ST_AN_DONE      8'h69
`define ST_TA_ACCEPT    8'h70
`define ST_TA_ENA_ON    8'h76
`define ST_TA_MOVED     8'h77
`define ST_TA_NONE      8'h78
`define ST_TA_DONE      8'h79
// timing
`define CLK_HZ          50000000
`define ENA_WAIT_S      10
`define MEAS_TIME_S     8
`endif

/* File: src/adjust_pkg.sv */
package adjust_pkg;
	typedef enum logic [3:0] {
		S_IDLE     = 4'b0000,
		S_PH_WAIT  = 4'b0001,
		S_PH_ENA   = 4'b0010,
		S_PH_TURN  = 4'b0011,
		S_PH_POLES = 4'b0100,
		S_FX_WAIT  = 4'b0101,
		S_FX_RUN   = 4'b0110,
		S_AN_RUN   = 4'b0111,
		S_TA_RUN   = 4'b1000
	} adj_state_t;
endpackage : adjust_pkg

/* File: src/motor_auto_adjust_sequencer.sv */
`include "adjust_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module motor_auto_adjust_sequencer #(
	parameter int unsigned ENA_WAIT_CYC = `ENA_WAIT_S * `CLK_HZ,
	parameter int unsigned MEAS_CYC     = `MEAS_TIME_S * `CLK_HZ
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic        enable_i,
	input  wire logic [15:0] phasing_speed_i,
	input  wire logic [7:0]  pole_count_i,
	input  wire logic        elec_period_i,
	input  wire logic        pole_found_i,
	input  wire logic [15:0] rotor_angle_i,
	input  wire logic        analog_done_i,
	input  wire logic        tacho_done_i,
	input  wire logic        tacho_moved_i,
	input  wire logic        tacho_absent_i,
	output logic             rotate_o,
	output logic      [15:0] speed_cmd_o,
	output logic             hold_angle_o,
	output logic      [15:0] feed_angle_o,
	output logic             analog_cal_o,
	output logic             tacho_cal_o,
	output logic      [7:0]  status_code_o,
	output adjust_pkg::adj_state_t state_o
);
	import adjust_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		adj_state_t  st;
		logic [15:0] cmd;
		logic [15:0] offset;
		logic [7:0]  status;
		logic [31:0] timer;
		logic [7:0]  periods;
		logic [15:0] rdata;
		logic        rotate;
		logic [15:0] speed;
		logic        hold;
		logic        analog;
		logic        tacho;
	} seq_t;

	seq_t s_q;
	seq_t s_d;
	logic cmd_wr;
	logic ofs_wr;
	logic [7:0] half_poles;

	////////////////////////////////////////////////////////////////////////
	// register decode
	assign cmd_wr     = reg_wr_i && (reg_addr_i == `REG_ADJ_CMD);
	assign ofs_wr     = reg_wr_i && (reg_addr_i == `REG_FB_OFFSET);
	assign half_poles = {1'b0, pole_count_i[7:1]};

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		s_d = s_q;
		// parameter writes from the service link
		if (cmd_wr) begin
			s_d.cmd = reg_wdata_i;
		end
		if (ofs_wr) begin
			s_d.offset = reg_wdata_i;
		end
		if (s_q.timer != 32'h0000_0000) begin
			s_d.timer = s_q.timer - 32'h0000_0001;
		end
		unique case (s_q.st)
			S_IDLE: begin
				s_d.rotate = 1'b0;
				s_d.hold   = 1'b0;
				s_d.analog = 1'b0;
				s_d.tacho  = 1'b0;
				if (cmd_wr) begin
					unique case (reg_wdata_i)
						`FN_PHASING: begin
							s_d.st     = S_PH_WAIT;
							s_d.status = `ST_PH_ACCEPT;
							s_d.timer  = ENA_WAIT_CYC;
						end
						`FN_FIX_ANGLE: begin
							s_d.st    = S_FX_WAIT;
							s_d.timer = ENA_WAIT_CYC;
						end
						`FN_ANALOG_OFS: begin
							s_d.st     = S_AN_RUN;
							s_d.status = `ST_AN_ACCEPT;
							s_d.analog = 1'b1;
						end
						`FN_TACHO_OFS: begin
							s_d.st     = S_TA_RUN;
							s_d.status = `ST_TA_ACCEPT;
							s_d.tacho  = 1'b1;
						end
						default: begin
							s_d.st = S_IDLE;
						end
					endcase
				end
			end
			// phasing: wait for the operator to close enable
			S_PH_WAIT: begin
				if (enable_i) begin
					s_d.st     = S_PH_ENA;
					s_d.status = `ST_PH_ENABLED;
					s_d.timer  = MEAS_CYC;
				end else if (s_q.timer == 32'h0000_0000) begin
					s_d.st     = S_IDLE;
					s_d.status = `ST_NONE;
				end
			end
			// enable closed: apply current and start turning
			S_PH_ENA: begin
				if (!enable_i) begin
					s_d.st     = S_IDLE;
					s_d.status = `ST_PH_ENA_LOST;
				end else begin
					s_d.st      = S_PH_TURN;
					s_d.status  = `ST_PH_CURRENT;
					s_d.rotate  = 1'b1;
					s_d.speed   = phasing_speed_i;
					s_d.periods = 8'h00;
				end
			end
			// count electrical periods up to half the pole count
			S_PH_TURN: begin
				s_d.speed = phasing_speed_i;
				if (elec_period_i) begin
					s_d.periods = s_q.periods + 8'h01;
				end
				if (!enable_i) begin
					s_d.st     = S_IDLE;
					s_d.rotate = 1'b0;
					s_d.status = `ST_PH_ENA_LOST;
				end else if (s_q.timer == 32'h0000_0000) begin
					s_d.st     = S_IDLE;
					s_d.rotate = 1'b0;
					s_d.status = `ST_PH_TIMEOUT;
				end else if (s_q.periods >= half_poles
					&& pole_found_i) begin
					s_d.st     = S_PH_POLES;
					s_d.rotate = 1'b0;
					s_d.status = `ST_PH_POLES;
				end
			end
			// poles determined: store angle and finish
			S_PH_POLES: begin
				s_d.rotate = 1'b0;
				if (!enable_i) begin
					s_d.st     = S_IDLE;
					s_d.status = `ST_PH_ENA_LOST;
				end else begin
					s_d.st     = S_IDLE;
					s_d.offset = rotor_angle_i;
					s_d.status = `ST_PH_DONE;
				end
			end
			// fixed angle: wait for enable, then hold the angle
			S_FX_WAIT: begin
				if (enable_i) begin
					s_d.st   = S_FX_RUN;
					s_d.hold = 1'b1;
				end else if (s_q.timer == 32'h0000_0000) begin
					s_d.st = S_IDLE;
				end
			end
			S_FX_RUN: begin
				if (!enable_i) begin
					s_d.st   = S_IDLE;
					s_d.hold = 1'b0;
				end
			end
			// analog offset: enable must stay open
			S_AN_RUN: begin
				if (enable_i) begin
					s_d.st     = S_IDLE;
					s_d.analog = 1'b0;
					s_d.status = `ST_AN_ENA_ON;
				end else if (analog_done_i) begin
					s_d.st     = S_IDLE;
					s_d.analog = 1'b0;
					s_d.status = `ST_AN_DONE;
				end
			end
			// tacho offset: errors take priority over done
			S_TA_RUN: begin
				if (enable_i) begin
					s_d.st     = S_IDLE;
					s_d.tacho  = 1'b0;
					s_d.status = `ST_TA_ENA_ON;
				end else if (tacho_absent_i) begin
					s_d.st     = S_IDLE;
					s_d.tacho  = 1'b0;
					s_d.status = `ST_TA_NONE;
				end else if (tacho_moved_i) begin
					s_d.st     = S_IDLE;
					s_d.tacho  = 1'b0;
					s_d.status = `ST_TA_MOVED;
				end else if (tacho_done_i) begin
					s_d.st     = S_IDLE;
					s_d.tacho  = 1'b0;
					s_d.status = `ST_TA_DONE;
				end
			end
			default: begin
				s_d.st = S_IDLE;
			end
		endcase
		if (!s_d.rotate) begin
			s_d.speed = `REG_RESET_VAL;
		end
		// read data follows the address every cycle
		unique case (reg_addr_i)
			`REG_FB_OFFSET: s_d.rdata = s_q.offset;
			`REG_ADJ_CMD:   s_d.rdata = s_q.cmd;
			default:        s_d.rdata = `REG_RESET_VAL;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s_q.st      <= S_IDLE;
			s_q.cmd     <= `REG_RESET_VAL;
			s_q.offset  <= `REG_RESET_VAL;
			s_q.status  <= `ST_NONE;
			s_q.timer   <= 32'h0000_0000;
			s_q.periods <= 8'h00;
			s_q.rdata   <= `REG_RESET_VAL;
			s_q.rotate  <= 1'b0;
			s_q.speed   <= `REG_RESET_VAL;
			s_q.hold    <= 1'b0;
			s_q.analog  <= 1'b0;
			s_q.tacho   <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign reg_rdata_o   = s_q.rdata;
	assign rotate_o      = s_q.rotate;
	assign speed_cmd_o   = s_q.speed;
	assign hold_angle_o  = s_q.hold;
	assign feed_angle_o  = s_q.offset;
	assign analog_cal_o  = s_q.analog;
	assign tacho_cal_o   = s_q.tacho;
	assign status_code_o = s_q.status;
	assign state_o       = s_q.st;
endmodule : motor_auto_adjust_sequencer
`default_nettype wire

/* File: test/adjust_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adjust_consts.svh"
module adjust_monitor
	import adjust_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic       enable_i,
	input wire logic [15:0] phasing_speed_i,
	input wire logic [15:0] rotor_angle_i,
	input wire logic       rotate_o,
	input wire logic [15:0] speed_cmd_o,
	input wire logic       hold_angle_o,
	input wire logic [7:0] status_code_o,
	input wire adj_state_t state_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// command write accepted while idle
	wire logic cmd_w = reg_wr_i && reg_addr_i == `REG_ADJ_CMD && state_o == S_IDLE;
	property p_start; cmd_w && reg_wdata_i == `FN_PHASING |=> status_code_o == `ST_PH_ACCEPT; endproperty
	a_start: assert property (p_start) else $error("phasing not accepted");
	property p_ena; state_o == S_PH_WAIT && enable_i |=> status_code_o == `ST_PH_ENABLED ##1 status_code_o == `ST_PH_CURRENT || !$past(enable_i); endproperty
	a_ena: assert property (p_ena) else $error("phasing order broken");
	property p_spd; rotate_o |-> speed_cmd_o == $past(phasing_speed_i); endproperty
	a_spd: assert property (p_spd) else $error("speed not followed");
	property p_lost; state_o == S_PH_TURN && !enable_i |=> status_code_o == `ST_PH_ENA_LOST && !rotate_o; endproperty
	a_lost: assert property (p_lost) else $error("enable loss not aborted");
	property p_done; status_code_o == `ST_PH_POLES && enable_i |=> status_code_o == `ST_PH_DONE; endproperty
	a_done: assert property (p_done) else $error("no completion");
	property p_hold; hold_angle_o && !enable_i |=> !hold_angle_o; endproperty
	a_hold: assert property (p_hold) else $error("fixed angle not stopped");
	property p_bad; cmd_w && reg_wdata_i > `FN_TACHO_OFS |=> state_o == S_IDLE [*3]; endproperty
	a_bad: assert property (p_bad) else $error("bad code started");
	property p_fx; cmd_w && reg_wdata_i == `FN_FIX_ANGLE |=> state_o == S_FX_WAIT && !rotate_o; endproperty
	a_fx: assert property (p_fx) else $error("fixed angle not entered");
endmodule : adjust_monitor
`default_nettype wire

/* File: test/pc_tool_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pc_tool_model (
	input  wire logic       clk_i,
	output logic            reg_wr_o,
	output logic     [7:0]  reg_addr_o,
	output logic     [15:0] reg_wdata_o
);
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 16'h0000;
	end
	// one-cycle parameter write, launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		// step off the edge where a previous write dropped its strobe
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge clk_i);
		#1 reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask : wr
endmodule : pc_tool_model
`default_nettype wire

/* File: test/tb_motor_auto_adjust_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adjust_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_motor_auto_adjust_sequencer;
	import adjust_pkg::*;
	logic clk, rst_n, wr, ena, per, found, an_done, ta_abs;
	logic [7:0] addr, st;
	logic [15:0] wdata, rdata, spd;
	logic rot, hold, an_cal, ta_cal, ta_done, ta_mov;
	logic [15:0] fang;
	adj_state_t state;
	int num_errors = 0, total_checks = 0, cyc = 0;
	pc_tool_model tool (.clk_i(clk), .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata));
	motor_auto_adjust_sequencer #(.ENA_WAIT_CYC(20), .MEAS_CYC(200)) dut (
		.clk_i(clk), .reset_n_i(rst_n), .reg_wr_i(wr), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .enable_i(ena),
		.phasing_speed_i(16'h0123), .pole_count_i(8'h04), .elec_period_i(per),
		.pole_found_i(found), .rotor_angle_i(16'h1234), .analog_done_i(an_done),
		.tacho_done_i(ta_done), .tacho_moved_i(ta_mov), .tacho_absent_i(ta_abs),
		.rotate_o(rot), .speed_cmd_o(spd), .hold_angle_o(hold),
		.feed_angle_o(fang), .analog_cal_o(an_cal),
		.tacho_cal_o(ta_cal), .status_code_o(st), .state_o(state));
	task automatic end_of_test();
		if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic wait_st(logic [7:0] c);
		for (int i = 0; i < 400 && st !== c; i++) step(1);
		`CHK(st, c)
	endtask : wait_st
	task automatic rd(logic [7:0] a, logic [15:0] e);
		tool.reg_addr_o = a;
		step(2);
		`CHK(rdata, e)
	endtask : rd
	task automatic t_phase_ok();
		tool.wr(`REG_ADJ_CMD, `FN_PHASING);
		step(0);
		`CHK(st, `ST_PH_ACCEPT)
		ena = 1'b1;
		step(1);
		`CHK(st, `ST_PH_ENABLED)
		step(1);
		`CHK({rot, st, spd}, {1'b1, `ST_PH_CURRENT, 16'h0123})
		found = 1'b1;
		per = 1'b1;
		step(1);
		per = 1'b0;
		step(3);
		`CHK(st, `ST_PH_CURRENT)
		per = 1'b1;
		step(1);
		per = 1'b0;
		wait_st(`ST_PH_POLES);
		wait_st(`ST_PH_DONE);
		found = 1'b0;
		ena = 1'b0;
		rd(`REG_FB_OFFSET, 16'h1234);
	endtask : t_phase_ok
	task automatic t_phase_fail();
		tool.wr(`REG_FB_OFFSET, 16'h0055);
		tool.wr(`REG_ADJ_CMD, `FN_PHASING);
		ena = 1'b1;
		wait_st(`ST_PH_CURRENT);
		ena = 1'b0;
		step(1);
		`CHK({rot, st}, {1'b0, `ST_PH_ENA_LOST})
		tool.wr(`REG_ADJ_CMD, `FN_PHASING);
		ena = 1'b1;
		wait_st(`ST_PH_TIMEOUT);
		ena = 1'b0;
		rd(`REG_FB_OFFSET, 16'h0055);
	endtask : t_phase_fail
	task automatic t_modes();
		tool.wr(`REG_FB_OFFSET, 16'h0ABC);
		tool.wr(`REG_ADJ_CMD, `FN_FIX_ANGLE);
		ena = 1'b1;
		step(2);
		`CHK({hold, fang}, {1'b1, 16'h0ABC})
		ena = 1'b0;
		step(2);
		`CHK(hold, 1'b0)
		tool.wr(`REG_ADJ_CMD, `FN_ANALOG_OFS);
		step(0);
		`CHK({an_cal, st}, {1'b1, `ST_AN_ACCEPT})
		an_done = 1'b1;
		step(1);
		an_done = 1'b0;
		wait_st(`ST_AN_DONE);
		tool.wr(`REG_ADJ_CMD, `FN_TACHO_OFS);
		step(0);
		`CHK({ta_cal, st}, {1'b1, `ST_TA_ACCEPT})
		ta_abs = 1'b1;
		step(1);
		ta_abs = 1'b0;
		wait_st(`ST_TA_NONE);
		tool.wr(`REG_ADJ_CMD, 16'h0009);
		step(2);
		`CHK({state, st}, {S_IDLE, `ST_TA_NONE})
		rd(`REG_FB_OFFSET, 16'h0ABC);
		rd(8'h50, 16'h0000);
	endtask : t_modes
	// tacho routine ending on movement, then on clean finish
	task automatic t_tacho();
		tool.wr(`REG_ADJ_CMD, `FN_TACHO_OFS);
		ta_mov = 1'b1;
		step(1);
		ta_mov = 1'b0;
		`CHK({ta_cal, st}, {1'b0, `ST_TA_MOVED})
		tool.wr(`REG_ADJ_CMD, `FN_TACHO_OFS);
		ta_done = 1'b1;
		step(1);
		ta_done = 1'b0;
		`CHK({ta_cal, st}, {1'b0, `ST_TA_DONE})
	endtask : t_tacho
	// clock, timeout and main sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		{rst_n, ena, per, found, an_done, ta_abs, ta_done, ta_mov} = '0;
		step(12);
		rst_n = 1'b1;
		t_phase_ok();
		t_phase_fail();
		t_modes();
		t_tacho();
		end_of_test();
	end
endmodule : tb_motor_auto_adjust_sequencer
bind motor_auto_adjust_sequencer adjust_monitor mon (.*);
`default_nettype wire
